//--- hdl/prc_top.sv
// Purpose: Regulator level and PLL parameter registers with burst write and lock status
// Assumes: Byte port; read data the cycle after the read strobe
// Notes:   PLL bytes move most significant first; any other access breaks a burst
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
module prc_top
    import prc_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_srst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire logic              i_lock_pin,
    output logic      [DATA_W-1:0] o_rdata,
    output logic      [LVL_W-1:0]  o_reg_level,
    output prc_pll_cfg_type        o_pll,
    output logic                   o_irq
);

    // Register state
    logic [LVL_W-1:0]    level;
    logic [LVL_W-1:0]    next_level;
    prc_pll_cfg_type     cfg;
    prc_pll_cfg_type     next_cfg;
    prc_pll_cfg_type     next_pll;
    logic [LVL_W-1:0]    next_reg_level;

    // Burst write state
    prc_burst_state_type state;
    prc_burst_state_type next_state;
    logic [2:0]          wr_idx;
    logic [2:0]          next_wr_idx;
    logic [39:0]         shadow;
    logic [39:0]         next_shadow;
    logic [47:0]         commit_word;
    logic                pll_wr;
    logic                commit;
    logic                abort;
    logic                bad_r;

    // Read state
    logic [2:0]          rd_idx;
    logic [2:0]          next_rd_idx;
    logic [DATA_W-1:0]   next_rdata;
    logic [5:0][7:0]     pll_view;

    // Interrupt state
    logic [IRQ_W-1:0]    status;
    logic [IRQ_W-1:0]    next_status;
    logic [IRQ_W-1:0]    mask;
    logic [IRQ_W-1:0]    next_mask;
    logic [IRQ_W-1:0]    events;
    logic [IRQ_W-1:0]    clr;
    logic                next_irq;

    // Lock monitor
    logic                locked;
    logic                lock_rise;
    logic                lock_fall;

    prc_lock_mon u_lock (
        .i_clk_sys  (i_clk_sys),
        .i_srst     (i_srst),
        .i_lock_pin (i_lock_pin),
        .i_enable   (cfg.en),
        .i_clear    (commit | ~cfg.en),
        .o_locked   (locked),
        .o_rise     (lock_rise),
        .o_fall     (lock_fall)
    );

    // Write side: regulator register and PLL burst assembly
    always_comb begin
        next_level  = level;
        next_cfg    = cfg;
        next_state  = state;
        next_wr_idx = wr_idx;
        next_shadow = shadow;
        commit      = 1'b0;
        abort       = 1'b0;
        bad_r       = 1'b0;
        pll_wr      = i_wr && (i_addr == ADDR_PLL);
        commit_word = {shadow, i_wdata} & PLL_WMASK;
        if (i_wr && (i_addr == ADDR_CORE_REG)) begin
            next_level = i_wdata[LVL_LSB +: LVL_W];
        end
        unique case (state)
            ST_IDLE: begin
                if (pll_wr) begin
                    next_shadow = {shadow[31:0], i_wdata};
                    next_wr_idx = 3'h1;
                    next_state  = ST_FILL;
                end
            end
            ST_FILL: begin
                if (pll_wr && (wr_idx == PLL_LAST)) begin
                    // Whole word lands at once so the loop never sees a mixed setting
                    commit        = 1'b1;
                    next_cfg.m    = commit_word[M_LSB +: 16];
                    next_cfg.n    = commit_word[N_LSB +: 16];
                    next_cfg.r    = commit_word[R_LSB +: 4];
                    next_cfg.x    = commit_word[X_LSB +: 2];
                    next_cfg.frac = commit_word[TYPE_BIT];
                    next_cfg.en   = commit_word[EN_BIT];
                    bad_r         = (next_cfg.r < R_MIN) || (next_cfg.r > R_MAX);
                    next_wr_idx   = 3'h0;
                    next_state    = ST_IDLE;
                end else if (pll_wr) begin
                    next_shadow = {shadow[31:0], i_wdata};
                    next_wr_idx = 3'(wr_idx + 3'h1);
                end else if (i_wr || i_rd) begin
                    // Partial burst is dropped, the live setting is untouched
                    abort       = 1'b1;
                    next_wr_idx = 3'h0;
                    next_state  = ST_IDLE;
                end
            end
        endcase
        // Integer-N drives a zero fraction to the loop
        next_pll   = next_cfg;
        next_pll.n = next_cfg.frac ? next_cfg.n : 16'h0000;
        next_reg_level = next_level;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            level       <= LVL_RESET;
            cfg         <= '{m: M_RESET, n: N_RESET, r: R_RESET, x: X_RESET,
                             frac: TYPE_RESET, en: EN_RESET};
            o_pll       <= '{m: M_RESET, n: N_RESET, r: R_RESET, x: X_RESET,
                             frac: TYPE_RESET, en: EN_RESET};
            o_reg_level <= LVL_RESET;
            state       <= ST_IDLE;
            wr_idx      <= 3'h0;
            shadow      <= 40'h00_0000_0000;
        end else begin
            level       <= next_level;
            cfg         <= next_cfg;
            o_pll       <= next_pll;
            o_reg_level <= next_reg_level;
            state       <= next_state;
            wr_idx      <= next_wr_idx;
            shadow      <= next_shadow;
        end
    end

    // Read side
    always_comb begin
        pll_view    = {cfg.m, cfg.n, 1'b0, cfg.r, cfg.x, cfg.frac, 6'h00, locked, cfg.en};
        next_rdata  = 8'h00;
        next_rd_idx = rd_idx;
        if (i_wr || i_rd) begin
            next_rd_idx = 3'h0;
        end
        if (i_rd) begin
            case (i_addr)
                ADDR_CORE_REG: next_rdata = {5'h00, level, 1'b0};
                ADDR_PLL: begin
                    next_rdata  = pll_view[3'(PLL_LAST - rd_idx)];
                    next_rd_idx = (rd_idx == PLL_LAST) ? 3'h0 : 3'(rd_idx + 3'h1);
                end
                ADDR_IRQ_STAT: next_rdata = {4'h0, status};
                ADDR_IRQ_MASK: next_rdata = {4'h0, mask};
                default:       next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_rdata <= 8'h00;
            rd_idx  <= 3'h0;
        end else begin
            o_rdata <= next_rdata;
            rd_idx  <= next_rd_idx;
        end
    end

    // Interrupts: set beats a same-cycle clear
    always_comb begin
        events = {bad_r, abort, lock_fall, lock_rise};
        clr    = (i_wr && (i_addr == ADDR_IRQ_STAT)) ? i_wdata[IRQ_W-1:0] : 4'h0;
        next_status = (status & ~clr) | events;
        next_mask   = (i_wr && (i_addr == ADDR_IRQ_MASK)) ? i_wdata[IRQ_W-1:0] : mask;
        next_irq    = |(next_status & next_mask);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            status <= IRQ_RESET;
            mask   <= IRQ_RESET;
            o_irq  <= 1'b0;
        end else begin
            status <= next_status;
            mask   <= next_mask;
            o_irq  <= next_irq;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    reset_values_a: assert property ($past(i_srst) |-> level == LVL_RESET && cfg.r == R_RESET)
        else $error("Reset values wrong");

    level_read_a: assert property (i_rd && i_addr == ADDR_CORE_REG && !i_wr |=>
            o_rdata == {5'h00, $past(level), 1'b0})
        else $error("Regulator readback wrong");

    denom_commit_a: assert property (pll_wr && state == ST_FILL && wr_idx == PLL_LAST |=>
            cfg.m == $past(shadow[39:24]))
        else $error("Denominator not committed");

    numer_commit_a: assert property (pll_wr && state == ST_FILL && wr_idx == PLL_LAST |=>
            cfg.n == $past(shadow[23:8]))
        else $error("Numerator not committed");

    divider_commit_a: assert property (commit |=>
            cfg.x == $past(shadow[2:1]) && cfg.r == $past(shadow[6:3]))
        else $error("Divider or integer not committed");

    partial_hold_a: assert property (!commit |=> cfg == $past(cfg))
        else $error("Setting changed without full burst");

    lock_read_a: assert property (i_rd && !i_wr && i_addr == ADDR_PLL && rd_idx == PLL_LAST
            |=> o_rdata[1] == $past(locked) && o_rdata[7:2] == 6'h00)
        else $error("Lock bit readback wrong");

    // A commit in the same cycle may switch to fractional, so only a settled integer-N counts
    int_zero_frac_a: assert property (!cfg.frac && !commit |=> o_pll.n == 16'h0000)
        else $error("Fraction not zero in integer mode");

    type_enable_out_a: assert property (commit |=>
            o_pll.frac == $past(shadow[0]) && o_pll.en == $past(i_wdata[EN_BIT]))
        else $error("Type or enable output stale");

    bad_r_flag_a: assert property (commit && (cfg.r != next_cfg.r) && bad_r |=>
            status[IRQ_BAD_R])
        else $error("Illegal integer not flagged");

    irq_level_a: assert property (o_irq == |(status & mask))
        else $error("Interrupt level mismatch");

    burst_done_c: cover property (commit);
    burst_abort_c: cover property (abort);
    lock_seen_c: cover property (lock_rise ##[1:20] (i_rd && i_addr == ADDR_PLL));
    irq_raise_c: cover property ($rose(o_irq));

endmodule

//--- pkg/prc_pkg.sv
// Purpose: Constants, field layout and types for the regulator and PLL settings block
// Assumes: Byte-wide register port, 16-bit register addresses
// Notes:   The 48-bit PLL register moves as six bytes, most significant byte first
//
// How it works
// - The regulator register keeps a 2-bit level at bits 2:1 (00 1.5V, 01 1.4V, 10 1.6V, 11 1.7V), reset 01.
// - The denominator M is 16 bits, upper byte at bits 47:40, lower byte at bits 39:32.
// - The numerator N is 16 bits, upper byte at bits 31:24, lower byte at bits 23:16.
// - The integer R sits at bits 14:11, legal codes 2 to 8, reset 3; an illegal code still commits and sets the bad-R interrupt flag.
// - The input divider at bits 10:9 gives no division or divide by 2, 3 or 4, reset 00.
// - Bit 1 is a read-only sticky lock flag; the written bit is ignored, and a clear enable bit or a completed burst with no lock seen that cycle clears it.
// - Bit 8 picks integer-N when 0 and fractional operation when 1.
// - Bit 0 enables the PLL when set.
// - The PLL register changes only when all six bytes of one burst have arrived.
// - The loop divides by R plus N/M, with N/M taken as zero in integer-N mode.
package prc_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // Register addresses
    localparam logic [15:0] ADDR_CORE_REG = 16'h4001;
    localparam logic [15:0] ADDR_PLL      = 16'h4002;
    localparam logic [15:0] ADDR_IRQ_STAT = 16'h4004;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'h4005;

    // Regulator register layout
    localparam int         LVL_LSB   = 1;
    localparam int         LVL_W     = 2;
    localparam logic [1:0] LVL_RESET = 2'h1;

    // PLL register layout
    localparam logic [2:0]  PLL_LAST   = 3'h5;
    localparam int          M_LSB      = 32;
    localparam int          N_LSB      = 16;
    localparam int          R_LSB      = 11;
    localparam int          X_LSB      = 9;
    localparam int          TYPE_BIT   = 8;
    localparam int          LOCK_BIT   = 1;
    localparam int          EN_BIT     = 0;
    localparam logic [47:0] PLL_WMASK  = 48'hFFFF_FFFF_7F01;
    localparam logic [15:0] M_RESET    = 16'h0753;
    localparam logic [15:0] N_RESET    = 16'h0287;
    localparam logic [3:0]  R_RESET    = 4'h3;
    localparam logic [3:0]  R_MIN      = 4'h2;
    localparam logic [3:0]  R_MAX      = 4'h8;
    localparam logic [1:0]  X_RESET    = 2'h0;
    localparam logic        TYPE_RESET = 1'b1;
    localparam logic        EN_RESET   = 1'b1;

    // Interrupt status bits
    localparam int         IRQ_W       = 4;
    localparam int         IRQ_LOCKED  = 0;
    localparam int         IRQ_UNLOCK  = 1;
    localparam int         IRQ_ABORT   = 2;
    localparam int         IRQ_BAD_R   = 3;
    localparam logic [3:0] IRQ_RESET   = 4'h0;

    typedef struct packed {
        logic [15:0] m;
        logic [15:0] n;
        logic [3:0]  r;
        logic [1:0]  x;
        logic        frac;
        logic        en;
    } prc_pll_cfg_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_FILL = 1'b1
    } prc_burst_state_type;

endpackage

//--- hdl/prc_lock_mon.sv
// Purpose: Synchronise the analog lock pin and keep a sticky lock flag
// Assumes: Lock pin is asynchronous to i_clk_sys
// Notes:   Flag clears on request; a lock seen in the same cycle wins
`timescale 1ns/1ps
module prc_lock_mon
    import prc_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_srst,
    input  wire logic i_lock_pin,
    input  wire logic i_enable,
    input  wire logic i_clear,
    output logic      o_locked,
    output logic      o_rise,
    output logic      o_fall
);

    logic sync1;
    logic sync2;
    logic sync3;
    logic next_locked;
    logic next_rise;
    logic next_fall;

    always_comb begin
        next_locked = (o_locked & ~i_clear) | (sync2 & i_enable);
        next_rise   = sync2 & ~sync3 & i_enable;
        next_fall   = ~sync2 & sync3;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sync1    <= 1'b0;
            sync2    <= 1'b0;
            sync3    <= 1'b0;
            o_locked <= 1'b0;
            o_rise   <= 1'b0;
            o_fall   <= 1'b0;
        end else begin
            sync1    <= i_lock_pin;
            sync2    <= sync1;
            sync3    <= sync2;
            o_locked <= next_locked;
            o_rise   <= next_rise;
            o_fall   <= next_fall;
        end
    end

endmodule

//--- test/prc_lock_src.sv
// Purpose: Behavioural model of the analog loop that reports lock on the lock pin
// Assumes: Loop settles a fixed number of cycles after its settings stop changing
// Notes:   Pin drops at once on any settings change, so software must re-wait for lock
`timescale 1ns/1ps
module prc_lock_src
    import prc_pkg::*;
#(
    parameter int LOCK_DLY = 60
)(
    input  wire logic            i_clk_sys,
    input  wire prc_pll_cfg_type i_pll,
    output logic                 o_lock_pin
);
    prc_pll_cfg_type last;
    int              cnt;

    initial begin
        o_lock_pin = 1'b0;
        cnt = 0;
        last = '0;
    end

    // A real loop loses lock when its divider moves, not only when disabled
    always @(posedge i_clk_sys) begin
        if (!i_pll.en || i_pll !== last) begin
            cnt <= 0;
            o_lock_pin <= 1'b0;
        end else if (cnt < LOCK_DLY) begin
            cnt <= cnt + 1;
        end else begin
            o_lock_pin <= 1'b1;
        end
        last <= i_pll;
    end
endmodule

//--- test/pll_and_regulator_config_bench.sv
// Purpose: Self-checking bench for the regulator level and PLL settings block
// Assumes: Lock pin comes from the loop model; byte port as in the package
// Notes:   Expected values come from an integer model of the registers
`timescale 1ns/1ps
module pll_and_regulator_config_bench
    import prc_pkg::*;
;
    logic                   i_clk_sys = 1'b0;
    logic                   i_srst    = 1'b1;
    logic            [15:0] i_addr    = 16'h0000;
    logic            [7:0]  i_wdata   = 8'h00;
    logic                   i_wr      = 1'b0;
    logic                   i_rd      = 1'b0;
    logic                   i_lock_pin;
    logic            [7:0]  o_rdata;
    logic            [1:0]  o_reg_level;
    prc_pll_cfg_type        o_pll;
    logic                   o_irq;
    int                     mismatches   = 0;
    int                     total_checks = 0;
    int                     seed         = 22;
    int                     k;
    int                     e_m, e_n, e_r, e_x, e_f, e_e;

    always #20 i_clk_sys = ~i_clk_sys;

    prc_top uut (
        .i_clk_sys   (i_clk_sys),
        .i_srst      (i_srst),
        .i_addr      (i_addr),
        .i_wdata     (i_wdata),
        .i_wr        (i_wr),
        .i_rd        (i_rd),
        .i_lock_pin  (i_lock_pin),
        .o_rdata     (o_rdata),
        .o_reg_level (o_reg_level),
        .o_pll       (o_pll),
        .o_irq       (o_irq)
    );

    prc_lock_src loop_model (
        .i_clk_sys  (i_clk_sys),
        .i_pll      (o_pll),
        .o_lock_pin (i_lock_pin)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Output numerator is zero in integer-N mode
    task automatic chkp(input prc_pll_cfg_type got);
        prc_pll_cfg_type exp;
        exp = prc_pll_cfg_type'({e_m[15:0], ((e_f != 0) ? e_n[15:0] : 16'h0000),
                                 e_r[3:0], e_x[1:0], e_f[0], e_e[0]});
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        i_addr <= a;
        i_wdata <= d;
    endtask

    task automatic idle();
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
    endtask

    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        wr(a, d);
        idle();
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk8(o_rdata, exp);
    endtask

    task automatic rdpll(input logic lock);
        logic [47:0] v;
        v = {e_m[15:0], e_n[15:0], 1'b0, e_r[3:0], e_x[1:0], e_f[0], 6'h00, lock, e_e[0]};
        for (int i = 0; i < 6; i++) begin
            rd(ADDR_PLL, v[47-8*i -: 8]);
        end
    endtask

    // Reserved and lock bits are written as ones to prove they are ignored
    task automatic cfg(input logic [15:0] m, input logic [15:0] n, input logic [3:0] r,
                       input logic [1:0] x, input logic f, input logic e);
        logic [47:0] v;
        e_m = m;
        e_n = n;
        e_r = r;
        e_x = x;
        e_f = f;
        e_e = e;
        v = {m, n, 1'b1, r, x, f, 6'h3F, 1'b1, e};
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_PLL, v[47-8*i -: 8]);
        end
        idle();
        repeat (2) @(posedge i_clk_sys);
        #1;
        chkp(o_pll);
    endtask

    initial begin
        e_m = M_RESET;
        e_n = N_RESET;
        e_r = R_RESET;
        e_x = X_RESET;
        e_f = TYPE_RESET;
        e_e = EN_RESET;
        repeat (4) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        #1;
        chkp(o_pll);
        chk8({6'h00, o_reg_level}, {6'h00, LVL_RESET});
        rdpll(1'b0);
        rd(ADDR_CORE_REG, 8'h02);
        wreg(16'h4003, 8'hFF);
        rd(16'h4003, 8'h00);
        rd(ADDR_IRQ_STAT, 8'h00);
        for (k = 3; k >= 0; k--) begin
            wreg(ADDR_CORE_REG, {5'h1F, k[1:0], 1'b1});
            chk8({6'h00, o_reg_level}, {6'h00, k[1:0]});
            rd(ADDR_CORE_REG, {5'h00, k[1:0], 1'b0});
        end
        // Lock gained raises the interrupt once unmasked
        wreg(ADDR_IRQ_MASK, 8'h01);
        for (k = 0; k < 200; k++) begin
            if (o_irq === 1'b1) begin
                break;
            end
            @(posedge i_clk_sys);
            #1;
        end
        if (k == 200) begin
            mismatches++;
            conclude();
        end
        rd(ADDR_IRQ_STAT, 8'h01);
        rdpll(1'b1);
        wreg(ADDR_IRQ_MASK, 8'h00);
        chk8({7'h00, o_irq}, 8'h00);
        wreg(ADDR_IRQ_MASK, 8'h01);
        chk8({7'h00, o_irq}, 8'h01);
        wreg(ADDR_IRQ_STAT, 8'h01);
        chk8({7'h00, o_irq}, 8'h00);
        rd(ADDR_IRQ_STAT, 8'h00);
        // Partial burst broken by another write must leave the settings alone
        wreg(ADDR_IRQ_MASK, 8'h04);
        for (k = 0; k < 3; k++) begin
            wr(ADDR_PLL, 8'hA5);
        end
        wreg(ADDR_CORE_REG, 8'h02);
        chkp(o_pll);
        chk8({7'h00, o_irq}, 8'h01);
        rd(ADDR_IRQ_STAT, 8'h04);
        rdpll(1'b1);
        wreg(ADDR_IRQ_STAT, 8'h04);
        // 12 MHz master clock settings: M 125 N 12 R 4, then M 625 N 477 R 3
        cfg(16'h007D, 16'h000C, 4'h4, 2'h0, 1'b1, 1'b1);
        // Pin still shows lock through the synchroniser when the commit clears, so set wins
        rdpll(1'b1);
        cfg(16'h0271, 16'h01DD, 4'h3, 2'h0, 1'b1, 1'b1);
        rdpll(1'b0);
        cfg(16'h007D, 16'h000C, 4'h4, 2'h0, 1'b0, 1'b0);
        for (k = 0; k < 4; k++) begin
            cfg(16'($random(seed)), 16'($random(seed)), 4'(2 + 2 * k), k[1:0], 1'b1, 1'b0);
            rdpll(1'b0);
        end
        wreg(ADDR_IRQ_STAT, 8'h0F);
        wreg(ADDR_IRQ_MASK, 8'h08);
        cfg(16'h0001, 16'h0000, 4'h9, 2'h3, 1'b1, 1'b0);
        chk8({7'h00, o_irq}, 8'h01);
        conclude();
    end
endmodule
